/* src/irq_ctrl_timer_watchdog.sv */
module irq_ctrl_timer_watchdog
  import irq_ctrl_pkg::*;
#(
  parameter int WD_W = 16,
  parameter logic [WD_W-1:0] WD_PERIOD_RST = WD_PERIOD_DEF[WD_W-1:0]
)(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // peripheral event pulses
  input wire logic [NPERIPH-1:0] i_periph_events,
  // core side
  output logic o_irq,
  output logic [7:0] o_vector,
  output logic o_vec_valid,
  output logic o_chip_reset
);
  // ****************************************
  // parameter check
  // ****************************************
  if (WD_W < 8 || WD_W > 31)
  begin : g_bad_wd
    $error("WD_W must be 8 to 31");
  end

  // ****************************************
  // apb decode
  // ****************************************
  logic setup_ph;
  logic wr_acc;
  logic mapped;
  assign setup_ph = i_psel && !i_penable;
  assign wr_acc = i_psel && i_penable && i_pwrite;
  assign o_pready = 1'b1;

  always_comb
  begin
    case (i_paddr)
      OFS_STATUS, OFS_MASK, OFS_VECTOR, OFS_PRIO_LO,
      OFS_PRIO_HI, OFS_TMR_CFG, OFS_TMR_CMD, OFS_TMR_CNT,
      OFS_WD_PERIOD, OFS_WD_ACK:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  end

  logic wr_status;
  logic wr_mask;
  logic wr_prio_lo;
  logic wr_prio_hi;
  logic wr_tcfg;
  logic wr_wdper;
  logic tmr_start;
  logic tmr_stop;
  logic wd_ack;
  assign wr_status = wr_acc && (i_paddr == OFS_STATUS);
  assign wr_mask = wr_acc && (i_paddr == OFS_MASK);
  assign wr_prio_lo = wr_acc && (i_paddr == OFS_PRIO_LO);
  assign wr_prio_hi = wr_acc && (i_paddr == OFS_PRIO_HI);
  assign wr_tcfg = wr_acc && (i_paddr == OFS_TMR_CFG);
  assign wr_wdper = wr_acc && (i_paddr == OFS_WD_PERIOD);
  assign tmr_start = wr_acc && (i_paddr == OFS_TMR_CMD) && i_pwdata[CMD_START_BIT];
  assign tmr_stop = wr_acc && (i_paddr == OFS_TMR_CMD) && i_pwdata[CMD_STOP_BIT];
  assign wd_ack = wr_acc && (i_paddr == OFS_WD_ACK);

  // ****************************************
  // control registers
  // ****************************************
  logic [NSRC-1:0] mask_reg;
  logic [31:0] prio_lo_reg;
  logic [19:0] prio_hi_reg;
  tmr_cfg_s tcfg_reg;
  logic [WD_W-1:0] wdper_reg;

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      mask_reg <= MASK_RST;
    else if (wr_mask)
      mask_reg <= i_pwdata[NSRC-1:0];
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      prio_lo_reg <= PRIO_LO_RST;
      prio_hi_reg <= PRIO_HI_RST;
    end
    else
    begin
      if (wr_prio_lo)
        prio_lo_reg <= i_pwdata;
      if (wr_prio_hi)
        prio_hi_reg <= i_pwdata[19:0];
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      tcfg_reg <= TMR_CFG_RST;
    else if (wr_tcfg)
      tcfg_reg <= i_pwdata[15:0];
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      wdper_reg <= WD_PERIOD_RST;
    else if (wr_wdper)
      wdper_reg <= i_pwdata[WD_W-1:0];
  end

  // ****************************************
  // timer and watchdog sources
  // ****************************************
  logic [11:0] tmr_count;
  logic tmr_running;
  logic tmr_expire;
  logic [WD_W-1:0] wd_count;
  logic wd_expire;

  general_timer_event u_timer (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_cfg(tcfg_reg),
    .i_start(tmr_start),
    .i_stop(tmr_stop),
    .o_count(tmr_count),
    .o_running(tmr_running),
    .o_expire(tmr_expire)
  );

  wdog_timer #(
    .WD_W(WD_W)
  ) u_wdog (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_period(wdper_reg),
    .i_ack(wd_ack),
    .o_count(wd_count),
    .o_expire(wd_expire),
    .o_chip_reset(o_chip_reset)
  );

  // ****************************************
  // pending flags
  // ****************************************
  logic [NSRC-1:0] src_ev;
  logic [NSRC-1:0] pend_reg;
  logic [NSRC-1:0] clr;
  logic [NSRC-1:0] act;
  assign src_ev = {i_periph_events[NPERIPH-1:2], wd_expire, tmr_expire,
                   i_periph_events[1:0]};
  assign clr = wr_status ? i_pwdata[NSRC-1:0] : '0;

  // set wins over a clear in the same cycle
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      pend_reg <= '0;
    else
      pend_reg <= (pend_reg & ~clr) | src_ev;
  end

  assign act = pend_reg & mask_reg;
  assign o_irq = |act;

  // ****************************************
  // programmable priority arbiter
  // ****************************************
  logic [51:0] prio_all;
  logic [3:0] slot_src [NSRC];
  logic [NSRC-1:0] slot_hit;
  logic [NSRC-1:0] slot_dec [NSRC];
  assign prio_all = {prio_hi_reg, prio_lo_reg};

  // slot 0 is served first; a slot holding no valid source index is skipped

  for (genvar k = 0; k < NSRC; k++)
  begin : g_slot
    assign slot_src[k] = prio_all[4*k +: 4];
    assign slot_hit[k] = (slot_src[k] < 4'(NSRC)) ? act[slot_src[k]] : 1'b0;
    assign slot_dec[k] = (slot_src[k] < 4'(NSRC)) ? (NSRC'(1) << slot_src[k]) : '0;
  end

  logic win_valid;
  logic [3:0] win_slot;
  logic [3:0] win_src;
  always_comb
  begin
    win_valid = 1'b0;
    win_slot = 4'h0;
    win_src = 4'h0;
    for (int k = NSRC - 1; k >= 0; k--)
    begin
      if (slot_hit[k])
      begin
        win_valid = 1'b1;
        win_slot = 4'(k);
        win_src = slot_src[k];
      end
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      o_vector <= 8'h00;
      o_vec_valid <= 1'b0;
    end
    else
    begin
      o_vector <= win_valid ? VEC_BASE + {4'h0, win_src} : 8'h00;
      o_vec_valid <= win_valid;
    end
  end

  // ****************************************
  // read data, captured in the setup phase
  // ****************************************
  logic [31:0] rdata;
  always_comb
  begin
    rdata = 32'h00000000;
    case (i_paddr)
      OFS_STATUS:
        rdata[NSRC-1:0] = pend_reg;
      OFS_MASK:
        rdata[NSRC-1:0] = mask_reg;
      OFS_VECTOR:
      begin
        rdata[VEC_VALID_BIT] = o_vec_valid;
        rdata[7:0] = o_vector;
      end
      OFS_PRIO_LO:
        rdata = prio_lo_reg;
      OFS_PRIO_HI:
        rdata[19:0] = prio_hi_reg;
      OFS_TMR_CFG:
        rdata[15:0] = tcfg_reg;
      OFS_TMR_CNT:
      begin
        rdata[CNT_RUN_BIT] = tmr_running;
        rdata[11:0] = tmr_count;
      end
      OFS_WD_PERIOD:
        rdata[WD_W-1:0] = wdper_reg;
      OFS_WD_ACK:
        rdata[WD_W-1:0] = wd_count;
      default:
        rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'b0;
    end
    else if (setup_ph)
    begin
      o_prdata <= rdata;
      o_pslverr <= !mapped;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic [NSRC-1:0] below;
  assign below = NSRC'((14'h0001 << win_slot) - 14'h0001);

  // sources that some priority slot names
  logic [NSRC-1:0] covered;
  always_comb
  begin
    covered = '0;
    for (int k = 0; k < NSRC; k++)
      covered = covered | slot_dec[k];
  end

  // ****************************************
  // event to core: flag and line, then vector
  // ****************************************
  sequence s_unmasked_event;
    |(src_ev & mask_reg & covered) && !wr_mask && !wr_prio_lo && !wr_prio_hi;
  endsequence

  sequence s_line_then_vector;
    o_irq ##1 o_vec_valid;
  endsequence

  a_event_to_vec: assert property (@(posedge i_mclk) disable iff (i_rst)
    s_unmasked_event |=> s_line_then_vector)
    else $error("event did not reach the core");

  a_irq_merge_vec: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_irq |=> o_vec_valid || $past(wr_mask) || $past(wr_status))
    else $error("interrupt without a vector");
  a_flag_set: assert property (@(posedge i_mclk) disable iff (i_rst)
    |src_ev |=> (pend_reg & $past(src_ev)) == $past(src_ev))
    else $error("event did not set its flag");
  a_flag_w1c: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_status && src_ev == '0 |=> (pend_reg & $past(i_pwdata[NSRC-1:0])) == '0)
    else $error("acknowledge did not clear flag");
  a_vector_unique: assert property (@(posedge i_mclk) disable iff (i_rst)
    win_valid |=> o_vec_valid && o_vector == VEC_BASE + {4'h0, $past(win_src)})
    else $error("vector does not match winner");
  a_prio_order: assert property (@(posedge i_mclk) disable iff (i_rst)
    win_valid |-> (slot_hit & below) == '0 && act[win_src])
    else $error("lower slot won over higher");
  a_timer_route: assert property (@(posedge i_mclk) disable iff (i_rst)
    tmr_expire |=> pend_reg[SRC_TIMER])
    else $error("timer event not routed");
  a_filterbank_route: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_periph_events[0] |=> pend_reg[SRC_FILTERBANK])
    else $error("filterbank event not routed");
  a_pending_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
    pend_reg[SRC_WDOG] && !wr_status |=> pend_reg[SRC_WDOG])
    else $error("pending flag lost");
  a_chip_reset_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_chip_reset |=> o_chip_reset)
    else $error("chip reset released before reset");

  for (genvar k = 0; k < NSRC; k++)
  begin : g_hold
    a_flag_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
      pend_reg[k] && !clr[k] |=> pend_reg[k])
      else $error("pending flag dropped without acknowledge");
  end
endmodule

/* pkg/irq_ctrl_pkg.sv */
package irq_ctrl_pkg;
  // ****************************************
  // sources
  // ****************************************
  localparam int NSRC = 13;
  localparam int SRC_FILTERBANK = 0;
  localparam int SRC_AUDIO_FULL = 1;
  localparam int SRC_TIMER = 2;
  localparam int SRC_WDOG = 3;
  localparam int NPERIPH = 11;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_VECTOR = 8'h08;
  localparam logic [7:0] OFS_PRIO_LO = 8'h0C;
  localparam logic [7:0] OFS_PRIO_HI = 8'h10;
  localparam logic [7:0] OFS_TMR_CFG = 8'h14;
  localparam logic [7:0] OFS_TMR_CMD = 8'h18;
  localparam logic [7:0] OFS_TMR_CNT = 8'h1C;
  localparam logic [7:0] OFS_WD_PERIOD = 8'h20;
  localparam logic [7:0] OFS_WD_ACK = 8'h24;
  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int VEC_VALID_BIT = 31;
  localparam int CNT_RUN_BIT = 31;
  localparam logic [7:0] VEC_BASE = 8'h20;
  localparam logic [12:0] MASK_RST = 13'h0000;
  localparam logic [31:0] PRIO_LO_RST = 32'h76543210;
  localparam logic [19:0] PRIO_HI_RST = 20'hCBA98;
  localparam logic [31:0] WD_PERIOD_DEF = 32'h0000FFFF;
  // ****************************************
  // timer configuration carrier
  // ****************************************
  typedef struct packed {
    logic cont;
    logic [2:0] presc;
    logic [11:0] reload;
  } tmr_cfg_s;
  localparam tmr_cfg_s TMR_CFG_RST = 16'h0000;
endpackage

/* src/general_timer_event.sv */
module general_timer_event
  import irq_ctrl_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // control
  input tmr_cfg_s i_cfg,
  input wire logic i_start,
  input wire logic i_stop,
  // state
  output logic [11:0] o_count,
  output logic o_running,
  output logic o_expire
);
  // ****************************************
  // prescaler: one tick every presc+1 cycles
  // ****************************************
  logic [2:0] pre_reg;
  logic tick;
  assign tick = o_running && (pre_reg == i_cfg.presc);
  always_ff @(posedge i_mclk)
  begin
    if (i_rst || i_start || tick || !o_running)
      pre_reg <= 3'h0;
    else
      pre_reg <= pre_reg + 3'h1;
  end
  // ****************************************
  // down counter
  // ****************************************
  always_ff @(posedge i_mclk)
  begin
    o_expire <= 1'b0;
    if (i_rst)
    begin
      o_count <= 12'h000;
      o_running <= 1'b0;
    end
    else if (i_start)
    begin
      o_count <= i_cfg.reload;
      o_running <= 1'b1;
    end
    else if (i_stop)
      o_running <= 1'b0;
    else if (tick)
    begin
      if (o_count <= 12'h001)
      begin
        o_expire <= 1'b1;
        o_count <= i_cfg.cont ? i_cfg.reload : 12'h000;
        o_running <= i_cfg.cont;
      end
      else
        o_count <= o_count - 12'h001;
    end
  end
  a_tmr_single_stop: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_expire && !$past(i_cfg.cont) |-> !o_running && o_count == 12'h000)
    else $error("single shot timer kept running");
  a_tmr_cont_reload: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_expire && $past(i_cfg.cont) |-> o_running && o_count == $past(i_cfg.reload))
    else $error("continuous timer did not reload");
  a_tmr_expire_cause: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_expire |-> $past(tick) && $past(o_count) <= 12'h001)
    else $error("timer expired away from zero");
endmodule

/* src/wdog_timer.sv */
module wdog_timer
  import irq_ctrl_pkg::*;
#(
  parameter int WD_W = 16
)(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // control
  input wire logic [WD_W-1:0] i_period,
  input wire logic i_ack,
  // state
  output logic [WD_W-1:0] o_count,
  output logic o_expire,
  output logic o_chip_reset
);
  logic fired_reg;
  logic hit;
  assign hit = (o_count >= i_period);
  // ****************************************
  // always counting; ack restarts the period
  // ****************************************
  always_ff @(posedge i_mclk)
  begin
    o_expire <= 1'b0;
    if (i_rst)
    begin
      o_count <= '0;
      fired_reg <= 1'b0;
      o_chip_reset <= 1'b0;
    end
    else if (i_ack)
    begin
      o_count <= '0;
      fired_reg <= 1'b0;
    end
    else if (hit)
    begin
      o_count <= '0;
      if (!fired_reg)
      begin
        o_expire <= 1'b1;
        fired_reg <= 1'b1;
      end
      else
        o_chip_reset <= 1'b1;
    end
    else
      o_count <= o_count + {{(WD_W-1){1'b0}}, 1'b1};
  end
  a_wd_ack_restart: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_ack |=> o_count == '0 && !fired_reg)
    else $error("watchdog ack did not restart");
  a_wd_first_irq: assert property (@(posedge i_mclk) disable iff (i_rst)
    hit && !i_ack && !fired_reg |=> o_expire && !o_chip_reset)
    else $error("first watchdog expiry not an interrupt");
  a_wd_second_reset: assert property (@(posedge i_mclk) disable iff (i_rst)
    hit && !i_ack && fired_reg |=> o_chip_reset && !o_expire)
    else $error("second watchdog expiry did not reset");
endmodule

/* sim/core_model.sv */
module core_model (
  // core side
  input wire logic i_mclk,
  input wire logic i_irq,
  input wire logic [7:0] i_vector,
  input wire logic i_vec_valid,
  // service record
  output logic [7:0] o_taken
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // vector fetch
  // ****************************************
  logic [7:0] taken_reg = 8'h00;
  assign o_taken = taken_reg;
  // the core branches only while the line is up and a vector is offered
  always @(posedge i_mclk)
  begin
    if (i_irq === 1'b1 && i_vec_valid === 1'b1)
    begin
      taken_reg <= i_vector;
    end
  end
endmodule

/* sim/tb.sv */
module tb import irq_ctrl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // signals
  // ****************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [NPERIPH-1:0] ev = 11'h000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [7:0] vec;
  logic vv;
  logic crst;
  logic [7:0] taken;
  logic [31:0] q;
  logic qerr;
  int errors = 0;
  int num_checks = 0;
  always #20 clk = ~clk;
  irq_ctrl_timer_watchdog irq_ctrl_timer_watchdog_i (
    .i_mclk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_periph_events(ev), .o_irq(irq), .o_vector(vec),
    .o_vec_valid(vv), .o_chip_reset(crst)
  );
  core_model core_model_i (
    .i_mclk(clk), .i_irq(irq), .i_vector(vec), .i_vec_valid(vv), .o_taken(taken)
  );
  // ****************************************
  // tasks
  // ****************************************
  task summarize;
    $display("errors=%0d checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // one apb transfer: setup, then access until pready is sampled high
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    qerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e, input string m);
    xfer(a, 1'b0, 32'h00000000);
    chk(q, e, m);
  endtask
  task pulse(input logic [10:0] b);
    @(posedge clk);
    ev <= b;
    @(posedge clk);
    ev <= 11'h000;
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    wait_n(8);
    rst <= 1'b0;
    rc(OFS_MASK, 32'h00000000, "mask reset");
    rc(OFS_PRIO_LO, PRIO_LO_RST, "prio lo reset");
    rc(OFS_PRIO_HI, {12'h000, PRIO_HI_RST}, "prio hi reset");
    rc(OFS_TMR_CFG, 32'h00000000, "timer cfg reset");
    rc(OFS_WD_PERIOD, 32'h0000FFFF, "wd period reset");
    rc(OFS_STATUS, 32'h00000000, "status reset");
    xfer(8'h3C, 1'b0, 32'h00000000);
    chk({31'h0, qerr}, 32'h00000001, "unmapped error");
    chk(q, 32'h00000000, "unmapped data");
    for (int i = 0; i < NPERIPH; i++)
    begin
      pulse(11'h001 << i);
      rc(OFS_STATUS, 32'h1 << (i < 2 ? i : i + 2), "source map");
      wr(OFS_STATUS, 32'h00001FFF);
    end
    wr(OFS_MASK, 32'h00001FFF);
    pulse(11'h021);
    wait_n(3);
    chk({31'h0, irq}, 32'h00000001, "irq up");
    rc(OFS_STATUS, 32'h00000081, "two pending");
    rc(OFS_VECTOR, 32'h80000020, "top vector");
    wr(OFS_PRIO_LO, 32'h06543217);
    rc(OFS_VECTOR, 32'h80000027, "reordered vector");
    wr(OFS_STATUS, 32'h00000080);
    rc(OFS_VECTOR, 32'h80000020, "lower kept pending");
    chk({24'h0, taken}, 32'h00000020, "core vector");
    wr(OFS_MASK, 32'h00001FFE);
    rc(OFS_VECTOR, 32'h00000000, "masked no vector");
    chk({31'h0, irq}, 32'h00000000, "masked no irq");
    rc(OFS_STATUS, 32'h00000001, "masked stays pending");
    wr(OFS_STATUS, 32'h00001FFF);
    wr(OFS_PRIO_LO, PRIO_LO_RST);
    wr(OFS_TMR_CFG, 32'h00001003);
    wr(OFS_TMR_CMD, 32'h00000001);
    rc(OFS_TMR_CNT, 32'h80000003, "prescaled count");
    wait_n(20);
    rc(OFS_STATUS, 32'h00000004, "single expiry");
    rc(OFS_TMR_CNT, 32'h00000000, "single stopped");
    wr(OFS_STATUS, 32'h00000004);
    wait_n(20);
    rc(OFS_STATUS, 32'h00000000, "no rerun");
    wr(OFS_TMR_CFG, 32'h00009003);
    wr(OFS_TMR_CMD, 32'h00000001);
    wait_n(20);
    wr(OFS_STATUS, 32'h00000004);
    wait_n(20);
    rc(OFS_STATUS, 32'h00000004, "continuous again");
    xfer(OFS_TMR_CNT, 1'b0, 32'h00000000);
    chk({31'h0, q[31]}, 32'h00000001, "continuous running");
    wr(OFS_TMR_CMD, 32'h00000002);
    wr(OFS_STATUS, 32'h00001FFF);
    wr(OFS_WD_ACK, 32'h00000000);
    wr(OFS_WD_PERIOD, 32'h00000010);
    wait_n(4);
    rc(OFS_STATUS, 32'h00000000, "wd not yet");
    wait_n(12);
    rc(OFS_STATUS, 32'h00000008, "wd first expiry");
    chk({31'h0, crst}, 32'h00000000, "no reset on first");
    wr(OFS_WD_ACK, 32'h00000000);
    wait_n(20);
    chk({31'h0, crst}, 32'h00000000, "ack restarts");
    wait_n(30);
    chk({31'h0, crst}, 32'h00000001, "second expiry reset");
    rst <= 1'b1;
    wait_n(8);
    rst <= 1'b0;
    wait_n(1);
    chk({31'h0, crst}, 32'h00000000, "reset clears");
    rc(OFS_WD_PERIOD, 32'h0000FFFF, "period back");
    summarize();
  end
  initial
  begin
    wait_n(20000);
    errors++;
    summarize();
  end
endmodule
